// file: hw/scp_pkg.sv
`default_nettype none
package scp_pkg;
    // ****************************************
    // address map
    // ****************************************
    localparam int unsigned ADDR_W          = 10;
    localparam logic [2:0]  OFF_CH_A_DATA   = 3'h0;
    localparam logic [2:0]  OFF_CH_A_CTRL   = 3'h1;
    localparam logic [2:0]  OFF_CH_B_DATA   = 3'h2;
    localparam logic [2:0]  OFF_CH_B_CTRL   = 3'h3;
    localparam logic [2:0]  OFF_BOARD_CS    = 3'h4;
    // ****************************************
    // board control/status fields
    // ****************************************
    localparam int unsigned BIT_TERM_A      = 0;
    localparam int unsigned BIT_TERM_B      = 1;
    localparam int unsigned BIT_DMA_EN      = 7;
    localparam int unsigned BIT_DSR_A       = 0;
    localparam int unsigned BIT_DSR_B       = 1;
    localparam logic        RST_TERM        = 1'b0;
    localparam logic        RST_DMA_EN      = 1'b0;
    localparam logic [6:0]  RST_BASE        = 7'h47;
    // ****************************************
    // baud reference
    // ****************************************
    localparam int unsigned BAUD_REF_HZ     = 7372800;
    localparam int unsigned CLK_HZ          = 100000000;
    localparam int unsigned BAUD_ACC_W      = 24;
    // phase step = 2^24 * ref / clk, rounded down
    localparam logic [BAUD_ACC_W-1:0] BAUD_STEP =
        BAUD_ACC_W'((64'(BAUD_REF_HZ) << BAUD_ACC_W) / 64'(CLK_HZ));
endpackage
`default_nettype wire

// file: hw/scp_sync.sv
`default_nettype none
module scp_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    // ****************************************
    // three-stage input filter
    // ****************************************
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // stage1 feeds only stage2, keeping metastability out of the compare
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // per bit: change accepted once stage2 and stage3 agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    level[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: hw/scp_top.sv
// Operation
// - eight addresses decoded from base; first four to controller, base+4 board port.
// - write bit 0 drives channel A terminal-ready, one asserts.
// - write bit 1 drives channel B terminal-ready, one asserts.
// - write bit 7 one enables DMA drivers, zero tri-states them.
// - read bit 0 returns channel A data-set-ready, one asserted.
// - read bit 1 returns channel B data-set-ready, one asserted.
// - controller baud generator clocked from 7.3728 MHz reference by default.
// - power-on reset clears software DMA enable.
// - permanent strap forces DMA drivers on; no strap keeps them off.
// - window offsets 0..3 select A data, A control, B data, B control.
// - only address lines A9..A3 compared against switch base.
`default_nettype none
module scp_top #(
    parameter int unsigned ADDR_W = scp_pkg::ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [7:0]        io_wdata,
    output logic      [7:0]        io_rdata,
    input  wire logic [6:0]        base_address_switch,
    input  wire logic              dma_enable_strap_perm,
    input  wire logic              dma_enable_strap_sw,
    input  wire logic              dsr_a_in,
    input  wire logic              dsr_b_in,
    input  wire logic [7:0]        ser_rdata,
    output logic                   ser_sel,
    output logic                   ser_ch_b,
    output logic                   ser_ctrl,
    output logic                   ser_wr,
    output logic                   ser_rd,
    output logic      [7:0]        ser_wdata,
    output logic                   term_ready_a,
    output logic                   term_ready_b,
    output logic                   dma_drv_oe,
    output logic                   baud_ref_clk
);
    // ****************************************
    // decode
    // ****************************************
    logic       board_hit;
    logic [2:0] off;
    logic       win_hit;
    logic       cs_hit;
    logic       ser_hit;
    logic [7:0] next_rdata;
    logic       dma_sw_en;
    logic [1:0] dsr_lvl;
    logic [6:0] base_q;
    logic       strap_perm_q;
    logic       strap_sw_q;
    logic [scp_pkg::BAUD_ACC_W-1:0] baud_acc;

    // only A9..A3 take part; higher lines are not wired in at all
    assign board_hit = (io_addr[9:3] == base_q);
    assign off       = io_addr[2:0];
    assign win_hit   = board_hit && (off <= scp_pkg::OFF_CH_B_CTRL);
    assign cs_hit    = board_hit && (off == scp_pkg::OFF_BOARD_CS);
    assign ser_hit   = win_hit && (io_wr || io_rd);

    // ****************************************
    // straps and switch, caught after reset release
    // ****************************************
    // switches and straps are static; a clocked capture keeps async reset constant-only
    // the base latch keeps its default until the first edge after release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            base_q <= scp_pkg::RST_BASE;
        end else begin
            base_q <= base_address_switch;
        end
    end

    // straps read as not fitted during reset, so the drivers start disabled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_perm_q <= 1'b0;
            strap_sw_q   <= 1'b0;
        end else begin
            strap_perm_q <= dma_enable_strap_perm;
            strap_sw_q   <= dma_enable_strap_sw;
        end
    end

    // ****************************************
    // modem status inputs
    // ****************************************
    scp_sync #(
        .W (2)
    ) u_dsr_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in ({dsr_b_in, dsr_a_in}),
        .level    (dsr_lvl)
    );

    // ****************************************
    // board control register
    // ****************************************
    // whole byte written at once; host keeps untouched bits itself
    // channel A terminal-ready follows bit 0 of every board write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            term_ready_a <= scp_pkg::RST_TERM;
        end else if (cs_hit && io_wr) begin
            term_ready_a <= io_wdata[scp_pkg::BIT_TERM_A];
        end
    end

    // channel B terminal-ready follows bit 1 of every board write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            term_ready_b <= scp_pkg::RST_TERM;
        end else if (cs_hit && io_wr) begin
            term_ready_b <= io_wdata[scp_pkg::BIT_TERM_B];
        end
    end

    // software dma enable; cleared by power-on reset so dma starts off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dma_sw_en <= scp_pkg::RST_DMA_EN;
        end else if (cs_hit && io_wr) begin
            dma_sw_en <= io_wdata[scp_pkg::BIT_DMA_EN];
        end
    end
    // bits 2..6 have no register behind them and simply fall away

    // driver enable: permanent strap overrides, software strap defers to bit 7
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dma_drv_oe <= 1'b0;
        end else begin
            dma_drv_oe <= strap_perm_q || (strap_sw_q && dma_sw_en);
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // unmapped offsets 5..7 and idle cycles read as zero
    // board read: unused bits 2..7 stay zero, status bits from the filter
    always_comb begin
        next_rdata = 8'h00;
        if (cs_hit && io_rd) begin
            next_rdata[scp_pkg::BIT_DSR_A] = dsr_lvl[0];
            next_rdata[scp_pkg::BIT_DSR_B] = dsr_lvl[1];
        end else if (win_hit && io_rd) begin
            next_rdata = ser_rdata;
        end
    end

    // registered so the host sees read data a fixed cycle after its strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= 8'h00;
        end else begin
            io_rdata <= next_rdata;
        end
    end

    // ****************************************
    // serial controller window
    // ****************************************
    // register select: bit1 picks channel B, bit0 picks control
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ser_sel  <= 1'b0;
            ser_ch_b <= 1'b0;
            ser_ctrl <= 1'b0;
        end else begin
            ser_sel  <= ser_hit;
            ser_ch_b <= off[1];
            ser_ctrl <= off[0];
        end
    end

    // one strobe cycle per host cycle; a held host strobe repeats the access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ser_wr <= 1'b0;
            ser_rd <= 1'b0;
        end else begin
            ser_wr <= win_hit && io_wr;
            ser_rd <= win_hit && io_rd;
        end
    end

    // data copied every cycle; only meaningful while ser_wr is high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ser_wdata <= 8'h00;
        end else begin
            ser_wdata <= io_wdata;
        end
    end

    // ****************************************
    // baud reference
    // ****************************************
    // phase accumulator approximates the reference; jitter of one clk period
    // trade-off: no second clock domain, at the cost of edge jitter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_acc <= '0;
        end else begin
            baud_acc <= baud_acc + scp_pkg::BAUD_STEP;
        end
    end

    // reference output from the accumulator's top bit, registered for a clean pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_ref_clk <= 1'b0;
        end else begin
            baud_ref_clk <= baud_acc[scp_pkg::BAUD_ACC_W-1];
        end
    end
endmodule
`default_nettype wire

// file: verif/scp_host.sv
`default_nettype none
module scp_host (
    input  wire logic       clk,
    output logic      [9:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        io_addr = 10'h000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // one strobe cycle; caller always hands a whole byte
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= w;
        io_rd <= !w;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        io_wdata <= ~d; // released data must not look held
        #1;
        q = io_rdata;
    endtask
endmodule
`default_nettype wire

// file: verif/scp_properties.sv
`default_nettype none
module scp_properties #(
    parameter int unsigned ADDR_W = scp_pkg::ADDR_W
) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic              io_wr,
    input wire logic              io_rd,
    input wire logic [7:0]        io_wdata,
    input wire logic [7:0]        io_rdata,
    input wire logic [6:0]        base_address_switch,
    input wire logic              dma_enable_strap_perm,
    input wire logic              dma_enable_strap_sw,
    input wire logic [7:0]        ser_rdata,
    input wire logic              ser_sel,
    input wire logic              ser_ch_b,
    input wire logic              ser_ctrl,
    input wire logic              ser_wr,
    input wire logic              ser_rd,
    input wire logic [7:0]        ser_wdata,
    input wire logic              term_ready_a,
    input wire logic              term_ready_b,
    input wire logic              dma_drv_oe
);
    // ****
    // decode
    // ****
    logic       brd;
    logic       win;
    logic [2:0] cyc;
    assign brd = io_addr[9:3] == base_address_switch && io_addr[2:0] == 3'h4;
    assign win = io_addr[9:3] == base_address_switch && !io_addr[2];
    // straps are only recaptured after reset, so wait a few edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            cyc <= 3'h0;
        else if (cyc != 3'h7)
            cyc <= cyc + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ta; io_wr && brd |=> term_ready_a == $past(io_wdata[0]); endproperty
    a_ta: assert property (p_ta) else $error("term a wrong");
    property p_tb; io_wr && brd |=> term_ready_b == $past(io_wdata[1]); endproperty
    a_tb: assert property (p_tb) else $error("term b wrong");
    property p_hold; !(io_wr && brd) |=> $stable({term_ready_a, term_ready_b}); endproperty
    a_hold: assert property (p_hold) else $error("term moved");
    property p_dma;
        io_wr && brd && !dma_enable_strap_perm |=>
            ##1 dma_drv_oe == (dma_enable_strap_sw & $past(io_wdata[7], 2));
    endproperty
    a_dma: assert property (p_dma) else $error("dma enable wrong");
    property p_perm; cyc > 3'h3 && dma_enable_strap_perm |-> dma_drv_oe; endproperty
    a_perm: assert property (p_perm) else $error("strap ignored");
    property p_rdz; io_rd && brd |=> io_rdata[7:2] == 6'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("unused bits set");
    property p_wrd; io_rd && win |=> io_rdata == $past(ser_rdata); endproperty
    a_wrd: assert property (p_wrd) else $error("window read wrong");
    property p_sel; (io_wr || io_rd) && win |=> ser_sel && {ser_ch_b, ser_ctrl} == $past(io_addr[1:0]); endproperty
    a_sel: assert property (p_sel) else $error("window select wrong");
    property p_nosel; !((io_wr || io_rd) && win) |=> !ser_sel && !ser_wr && !ser_rd; endproperty
    a_nosel: assert property (p_nosel) else $error("stray select");
    property p_wwr; io_wr && win |=> ser_wr && ser_wdata == $past(io_wdata); endproperty
    a_wwr: assert property (p_wwr) else $error("window write wrong");
    c_brd: cover property (io_wr && brd ##2 dma_drv_oe);
    c_win: cover property (io_rd && win);
    c_perm: cover property (dma_enable_strap_perm && dma_drv_oe);
endmodule
bind scp_top scp_properties #(.ADDR_W(ADDR_W)) u_props (.clk, .nrst, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .base_address_switch, .dma_enable_strap_perm, .dma_enable_strap_sw, .ser_rdata, .ser_sel,
    .ser_ch_b, .ser_ctrl, .ser_wr, .ser_rd, .ser_wdata, .term_ready_a, .term_ready_b, .dma_drv_oe);
`default_nettype wire

// file: verif/tb_serial_card_control_port.sv
`default_nettype none
module tb_serial_card_control_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, perm = 1'b0, swst = 1'b1, dsr_a = 1'b0, dsr_b = 1'b0;
    logic [6:0] base = 7'h47;
    logic [7:0] ser_rdata = 8'h00, io_wdata, io_rdata, ser_wdata, q;
    logic [9:0] io_addr;
    logic io_wr, io_rd, ser_sel, ser_ch_b, ser_ctrl, ser_wr, ser_rd, term_ready_a, term_ready_b;
    logic dma_drv_oe, baud_ref_clk;
    int n_errors = 0, cmp_count = 0, edges;
    logic [7:0] wv [6] = '{8'h83, 8'h7c, 8'h01, 8'h80, 8'h02, 8'h00};
    logic [9:0] ra [4] = '{10'h23d, 10'h23f, 10'h244, 10'h03c};
    always #5 clk = ~clk;
    scp_host u_host (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
    scp_top u_dut (.clk, .nrst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .base_address_switch(base),
        .dma_enable_strap_perm(perm), .dma_enable_strap_sw(swst), .dsr_a_in(dsr_a), .dsr_b_in(dsr_b),
        .ser_rdata, .ser_sel, .ser_ch_b, .ser_ctrl, .ser_wr, .ser_rd, .ser_wdata, .term_ready_a,
        .term_ready_b, .dma_drv_oe, .baud_ref_clk);
    // ****
    // tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // straps only count when captured out of reset
    task automatic do_rst(input logic [6:0] b, input logic p, input logic s);
        @(posedge clk);
        nrst <= 1'b0;
        base <= b;
        perm <= p;
        swst <= s;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // board write, then the outputs once the enable has caught up
    task automatic wr_chk(input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp);
        u_host.xfer(1'b1, a, d, q);
        @(posedge clk);
        #1;
        chk({dma_drv_oe, 5'h00, term_ready_b, term_ready_a}, exp);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        do_rst(7'h47, 1'b0, 1'b1);
        chk({dma_drv_oe, 5'h00, term_ready_b, term_ready_a}, 8'h00);
        foreach (wv[i]) wr_chk(10'h23c, wv[i], wv[i] & 8'h83);
        wr_chk(10'h23c, 8'h83, 8'h83);
        ser_rdata <= 8'h5a;
        foreach (ra[i]) begin
            wr_chk(ra[i], 8'h00, 8'h83);
            u_host.xfer(1'b0, ra[i], 8'h00, q);
            chk(q, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {dsr_b, dsr_a} <= i[1:0];
            ser_rdata <= 8'ha0 + 8'(i);
            repeat (6) @(posedge clk);
            u_host.xfer(1'b0, 10'h23c, 8'h00, q);
            chk(q, {6'h00, i[1:0]});
            u_host.xfer(1'b0, 10'h238 + 10'(i), 8'h00, q);
            chk(q, 8'ha0 + 8'(i));
            chk({3'h0, ser_sel, ser_rd, ser_wr, ser_ch_b, ser_ctrl}, 8'h18 | 8'(i));
            u_host.xfer(1'b1, 10'h238 + 10'(i), 8'h3c, q);
            chk({ser_wdata[5:0], ser_wr, ser_rd}, 8'hf2);
        end
        edges = 0;
        fork
            repeat (1000) @(posedge clk);
            forever @(posedge baud_ref_clk) edges++;
        join_any
        disable fork;
        chk(8'(edges >= 72 && edges <= 75), 8'h01);
        // dma enable and both terminal bits are set here; reset must clear them
        do_rst(7'h47, 1'b0, 1'b1);
        chk({dma_drv_oe, 5'h00, term_ready_b, term_ready_a}, 8'h00);
        do_rst(7'h60, 1'b1, 1'b0);
        wr_chk(10'h304, 8'h02, 8'h82);
        do_rst(7'h60, 1'b0, 1'b0);
        wr_chk(10'h304, 8'h81, 8'h01);
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
